// ===== dmc_front.sv
// ddr module pin front end: command decode, power states, data strobes
`timescale 1ns/1ns
module dmc_front
    import dmc_pkg::*;
#(
    parameter int LANES = LANES_DFLT,
    parameter int FIFO_DEPTH = FIFO_DEPTH_DFLT,
    parameter int READ_LAT = READ_LAT_DFLT,
    parameter int WRITE_WIN = WRITE_WIN_DFLT
) (
    input wire logic mclk, // system clock
    input wire logic rst_b, // async reset, active low
    input wire logic clock_pair_zero_p, // clock pair true leg
    input wire logic clock_pair_zero_n, // clock pair complement leg
    input wire logic rank_zero_clock_enable, // rank 0 clock enable
    input wire logic rank_one_clock_enable, // rank 1 clock enable
    input wire logic rank_zero_select_n, // rank 0 select, low active
    input wire logic rank_one_select_n, // rank 1 select, low active
    input wire logic ras_n, // row strobe, low active
    input wire logic cas_n, // column strobe, low active
    input wire logic we_n, // write enable, low active
    input wire logic [BA_W-1:0] bank_addr, // bank address
    input wire logic [ADDR_W-1:0] addr, // address lines
    input wire logic [LANES-1:0] write_mask, // per-lane write mask
    input wire logic [LANES*LANE_W-1:0] dq_in, // data pins in
    output logic [LANES*LANE_W-1:0] dq_out, // data pins out
    output logic dq_oe, // data pins driven
    input wire logic [LANES-1:0] dqs_in, // strobe pins in
    output logic [LANES-1:0] dqs_out, // strobe pins out
    output logic dqs_oe, // strobe pins driven
    output logic cmd_valid, // decoded command pulse
    output logic [3:0] cmd_code, // decoded command code
    output logic cmd_rank, // rank of command
    output logic [BA_W-1:0] cmd_bank, // bank of command
    output logic [ADDR_W-1:0] cmd_addr, // row or column
    output logic cmd_auto_pre, // auto-precharge flag
    output logic [ADDR_W-1:0] mode_base, // base mode register
    output logic [ADDR_W-1:0] mode_ext, // extended mode register
    output logic [2*BANKS-1:0] bank_open, // open rows, rank1 high
    output logic [3:0] rank_power, // power states, rank1 high
    input wire logic [2*LANES*LANE_W-1:0] read_data, // two read beats, first low
    output logic wr_valid, // write beat available
    input wire logic wr_ready, // consumer takes beat
    output logic [2*LANES*LANE_W-1:0] wr_data, // two write beats, first low
    output logic [2*LANES-1:0] wr_byte_en, // byte enables per beat
    output logic wr_buf_ready, // capture buffer has room
    output logic wr_overflow, // beat lost, sticky
    input wire logic overflow_clr // clears overflow flag
);
    // ------------------------------------------------------------
    // checks and widths
    // ------------------------------------------------------------
    localparam int DQ_W = LANES * LANE_W;
    localparam int PIN_W = 2 + RANKS * 2 + 3 + BA_W + ADDR_W + 2 * LANES + DQ_W;
    localparam int BEAT_W = 2 * DQ_W + 2 * LANES;

    initial begin
        if (LANES < 1 || READ_LAT < 1 || READ_LAT > 15 || WRITE_WIN < 1 || WRITE_WIN > 3) begin
            $error("dmc_front parameters out of range");
        end
    end

    function automatic logic [BANKS-1:0] bank_onehot(input logic [BA_W-1:0] ba);
        bank_onehot = '0;
        bank_onehot[ba] = 1'b1;
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [PIN_W-1:0] pin_meta_reg;
    logic [PIN_W-1:0] pin_sync_reg;
    logic ck_p_s, ck_n_s, ras_s, cas_s, we_s;
    logic [RANKS-1:0] cke_s, cs_s;
    logic [BA_W-1:0] ba_s;
    logic [ADDR_W-1:0] addr_s;
    logic [LANES-1:0] dm_s, dqs_s;
    logic [DQ_W-1:0] dq_s;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
        end else begin
            pin_meta_reg <= {clock_pair_zero_p, clock_pair_zero_n, rank_one_clock_enable,
                             rank_zero_clock_enable, rank_one_select_n, rank_zero_select_n,
                             ras_n, cas_n, we_n, bank_addr, addr, write_mask, dqs_in, dq_in};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    assign {ck_p_s, ck_n_s, cke_s, cs_s, ras_s, cas_s, we_s, ba_s, addr_s, dm_s, dqs_s,
            dq_s} = pin_sync_reg;

    // ------------------------------------------------------------
    // clock-pair and strobe edges
    // ------------------------------------------------------------
    logic ck_prev_reg;
    logic [LANES-1:0] dqs_prev_reg;
    wire ck_hi = ck_p_s & ~ck_n_s;
    wire pos_cross = ck_hi & ~ck_prev_reg;
    wire neg_cross = ~ck_hi & ck_prev_reg;
    wire [LANES-1:0] dqs_rise = dqs_s & ~dqs_prev_reg;
    wire [LANES-1:0] dqs_fall = ~dqs_s & dqs_prev_reg;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ck_prev_reg <= 1'b0;
            dqs_prev_reg <= '0;
        end else begin
            ck_prev_reg <= ck_hi;
            dqs_prev_reg <= dqs_s;
        end
    end

    // ------------------------------------------------------------
    // per-rank decoder, power state and open banks
    // ------------------------------------------------------------
    dmc_pwr_t pwr_reg [RANKS];
    logic [BANKS-1:0] open_reg [RANKS];
    logic [RANKS-1:0] rank_cmd;
    logic [RANKS-1:0] rank_on;
    wire [2:0] strobes = {ras_s, cas_s, we_s};
    wire ap_s = addr_s[AP_BIT];

    for (genvar r = 0; r < RANKS; r++) begin : g_rank
        dmc_pwr_t pwr_next;
        logic [BANKS-1:0] open_next;
        wire [3:0] code = {cs_s[r], strobes};
        wire [BANKS-1:0] hit = bank_onehot(ba_s);
        assign rank_on[r] = pwr_reg[r] == DMC_PWR_ON;
        // powered-down ranks hear only clock enable and the clock pair
        assign rank_cmd[r] = pos_cross & cke_s[r] & rank_on[r] & ~cs_s[r] &
                             (code != CMD_NOP);

        always_comb begin
            pwr_next = pwr_reg[r];
            case (pwr_reg[r])
                DMC_PWR_ON: begin
                    if (pos_cross && !cke_s[r]) begin
                        if (code == CMD_REF) begin
                            pwr_next = DMC_PWR_SELF;
                        end else if (|open_reg[r]) begin
                            pwr_next = DMC_PWR_ACT_PD;
                        end else begin
                            pwr_next = DMC_PWR_PRE_PD;
                        end
                    end
                end
                DMC_PWR_PRE_PD, DMC_PWR_ACT_PD: begin
                    if (pos_cross && cke_s[r]) begin
                        pwr_next = DMC_PWR_ON;
                    end
                end
                DMC_PWR_SELF: begin
                    if (cke_s[r]) begin
                        pwr_next = DMC_PWR_ON;
                    end
                end
                default: pwr_next = DMC_PWR_ON;
            endcase
        end

        always_comb begin
            open_next = open_reg[r];
            if (rank_cmd[r]) begin
                case (code)
                    CMD_ACT: open_next = open_reg[r] | hit;
                    CMD_PRE: open_next = ap_s ? '0 : (open_reg[r] & ~hit);
                    CMD_RD, CMD_WR: open_next = ap_s ? (open_reg[r] & ~hit) : open_reg[r];
                    default: open_next = open_reg[r];
                endcase
            end
        end

        always_ff @(posedge mclk or negedge rst_b) begin
            if (!rst_b) begin
                pwr_reg[r] <= DMC_PWR_ON;
                open_reg[r] <= '0;
            end else begin
                pwr_reg[r] <= pwr_next;
                open_reg[r] <= open_next;
            end
        end

        assign bank_open[r*BANKS +: BANKS] = open_reg[r];
        assign rank_power[r*2 +: 2] = pwr_reg[r];
    end

    // ------------------------------------------------------------
    // command report and mode registers
    // ------------------------------------------------------------
    wire any_cmd = |rank_cmd;
    wire sel_rank = ~rank_cmd[0];
    wire [3:0] cur_code = {1'b0, strobes};
    wire lmr_ev = any_cmd & (cur_code == CMD_LMR);
    wire rd_ev = any_cmd & (cur_code == CMD_RD);
    wire wr_ev = any_cmd & (cur_code == CMD_WR);

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_valid <= 1'b0;
            cmd_code <= CMD_NOP;
            cmd_rank <= 1'b0;
            cmd_bank <= '0;
            cmd_addr <= '0;
            cmd_auto_pre <= 1'b0;
        end else begin
            cmd_valid <= any_cmd;
            if (any_cmd) begin
                cmd_code <= cur_code;
                cmd_rank <= sel_rank;
                cmd_bank <= ba_s;
                cmd_addr <= addr_s;
                cmd_auto_pre <= (rd_ev | wr_ev) & ap_s;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mode_base <= MR_RESET;
            mode_ext <= MR_RESET;
        end else if (lmr_ev) begin
            if (ba_s == MR_BASE) begin
                mode_base <= addr_s;
            end else if (ba_s == MR_EXT) begin
                mode_ext <= addr_s;
            end
        end
    end

    // ------------------------------------------------------------
    // read launch, edge-aligned with the clock pair
    // ------------------------------------------------------------
    logic [3:0] rd_lat_reg;
    logic rd_drive_reg;
    logic rd_rank_reg;
    logic [2*DQ_W-1:0] rd_hold_reg;
    wire rd_start = pos_cross & (rd_lat_reg == 4'h1);
    // drivers drop as soon as clock enable falls, no clock edge needed
    wire rd_cke = rd_rank_reg ? cke_s[1] : cke_s[0];

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rd_lat_reg <= 4'h0;
            rd_drive_reg <= 1'b0;
            rd_rank_reg <= 1'b0;
            rd_hold_reg <= '0;
        end else begin
            if (rd_ev) begin
                rd_lat_reg <= 4'(READ_LAT);
                rd_rank_reg <= sel_rank;
                rd_hold_reg <= read_data;
            end else if (pos_cross && rd_lat_reg != 4'h0) begin
                rd_lat_reg <= rd_lat_reg - 4'h1;
            end
            if (rd_start) begin
                rd_drive_reg <= 1'b1;
            end else if (pos_cross || !rd_cke) begin
                rd_drive_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            dq_out <= '0;
            dqs_out <= '0;
        end else begin
            if (rd_start) begin
                dq_out <= rd_hold_reg[DQ_W-1:0];
                dqs_out <= '1;
            end else if (neg_cross && rd_drive_reg) begin
                dq_out <= rd_hold_reg[2*DQ_W-1:DQ_W];
                dqs_out <= '0;
            end
        end
    end

    assign dq_oe = rd_drive_reg & rd_cke;
    assign dqs_oe = rd_drive_reg & rd_cke;

    // ------------------------------------------------------------
    // write capture on both strobe edges per lane
    // ------------------------------------------------------------
    logic [1:0] wr_left_reg;
    logic wr_rank_reg;
    logic push_reg;
    logic [DQ_W-1:0] lo_data_reg, hi_data_reg;
    logic [LANES-1:0] lo_en_reg, hi_en_reg;
    wire wr_rank_on = wr_rank_reg ? rank_on[1] : rank_on[0];
    wire wr_open = (wr_left_reg != 2'h0) & wr_rank_on;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wr_left_reg <= 2'h0;
            wr_rank_reg <= 1'b0;
            push_reg <= 1'b0;
        end else begin
            if (wr_ev) begin
                wr_left_reg <= 2'(WRITE_WIN);
                wr_rank_reg <= sel_rank;
            end else if (pos_cross && wr_left_reg != 2'h0) begin
                wr_left_reg <= wr_left_reg - 2'h1;
            end
            push_reg <= wr_open & dqs_fall[0];
        end
    end

    for (genvar l = 0; l < LANES; l++) begin : g_lane
        always_ff @(posedge mclk or negedge rst_b) begin
            if (!rst_b) begin
                lo_data_reg[l*LANE_W +: LANE_W] <= '0;
                hi_data_reg[l*LANE_W +: LANE_W] <= '0;
                lo_en_reg[l] <= 1'b0;
                hi_en_reg[l] <= 1'b0;
            end else if (wr_open) begin
                if (dqs_rise[l]) begin
                    lo_data_reg[l*LANE_W +: LANE_W] <= dq_s[l*LANE_W +: LANE_W];
                    lo_en_reg[l] <= ~dm_s[l];
                end
                if (dqs_fall[l]) begin
                    hi_data_reg[l*LANE_W +: LANE_W] <= dq_s[l*LANE_W +: LANE_W];
                    hi_en_reg[l] <= ~dm_s[l];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // capture buffer and overflow flag
    // ------------------------------------------------------------
    logic [BEAT_W-1:0] beat_out;

    dmc_fifo #(
        .WIDTH(BEAT_W),
        .DEPTH(FIFO_DEPTH)
    ) u_wr_fifo (
        .mclk(mclk),
        .rst_b(rst_b),
        .in_valid(push_reg),
        .in_ready(wr_buf_ready),
        .in_data({hi_en_reg, lo_en_reg, hi_data_reg, lo_data_reg}),
        .out_valid(wr_valid),
        .out_ready(wr_ready),
        .out_data(beat_out)
    );

    assign {wr_byte_en, wr_data} = beat_out;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wr_overflow <= 1'b0;
        end else if (push_reg && !wr_buf_ready) begin
            wr_overflow <= 1'b1;
        end else if (overflow_clr) begin
            wr_overflow <= 1'b0;
        end
    end
endmodule

// ===== dmc_pkg.sv
// constants and types for the ddr module command front end
package dmc_pkg;
    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int RANKS = 2;
    localparam int BANKS = 4;
    localparam int BA_W = 2;
    localparam int ADDR_W = 13;
    localparam int AP_BIT = 10;
    localparam int LANE_W = 8;
    localparam int LANES_DFLT = 8;
    localparam int FIFO_DEPTH_DFLT = 4;

    // ------------------------------------------------------------
    // command codes {select_n, ras_n, cas_n, we_n}
    // ------------------------------------------------------------
    localparam logic [3:0] CMD_LMR = 4'h0;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_WR = 4'h4;
    localparam logic [3:0] CMD_RD = 4'h5;
    localparam logic [3:0] CMD_BST = 4'h6;
    localparam logic [3:0] CMD_NOP = 4'h7;

    // ------------------------------------------------------------
    // mode register select on bank address
    // ------------------------------------------------------------
    localparam logic [1:0] MR_BASE = 2'h0;
    localparam logic [1:0] MR_EXT = 2'h1;
    localparam logic [12:0] MR_RESET = 13'h0000;

    // ------------------------------------------------------------
    // timing counts in clock-pair cycles
    // ------------------------------------------------------------
    localparam int READ_LAT_DFLT = 3;
    localparam int WRITE_WIN_DFLT = 2;

    // ------------------------------------------------------------
    // rank power state, gray along active -> pd -> self refresh
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DMC_PWR_ON = 2'b00,
        DMC_PWR_PRE_PD = 2'b01,
        DMC_PWR_ACT_PD = 2'b11,
        DMC_PWR_SELF = 2'b10
    } dmc_pwr_t;
endpackage

// ===== dmc_fifo.sv
// small valid/ready fifo for captured write beats
`timescale 1ns/1ns
module dmc_fifo
    import dmc_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = FIFO_DEPTH_DFLT
) (
    input wire logic mclk, // system clock
    input wire logic rst_b, // async reset, active low
    input wire logic in_valid, // push request
    output logic in_ready, // room for a word
    input wire logic [WIDTH-1:0] in_data, // pushed word
    output logic out_valid, // word available
    input wire logic out_ready, // consumer takes word
    output logic [WIDTH-1:0] out_data // head word
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
            $error("dmc_fifo depth must be a power of two, at least 2");
        end
    end

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW:0] wr_ptr_reg;
    logic [PW:0] rd_ptr_reg;
    wire do_push = in_valid & in_ready;
    wire do_pop = out_valid & out_ready;

    assign in_ready = ~((wr_ptr_reg[PW] != rd_ptr_reg[PW]) &&
                        (wr_ptr_reg[PW-1:0] == rd_ptr_reg[PW-1:0]));
    assign out_valid = wr_ptr_reg != rd_ptr_reg;
    assign out_data = mem_reg[rd_ptr_reg[PW-1:0]];

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (do_push) begin
            mem_reg[wr_ptr_reg[PW-1:0]] <= in_data;
        end
    end
endmodule

// ===== dmc_front_monitor.sv
// assertion checker for the ddr module pin front end
`timescale 1ns/1ns
module dmc_front_monitor
    import dmc_pkg::*;
#(
    parameter int LANES = LANES_DFLT
) (
    input wire logic mclk, // clock
    input wire logic rst_b, // reset
    input wire logic rank_zero_clock_enable, // cke 0
    input wire logic rank_one_clock_enable, // cke 1
    input wire logic rank_zero_select_n, // select 0
    input wire logic rank_one_select_n, // select 1
    input wire logic dq_oe, // data drive
    input wire logic dqs_oe, // strobe drive
    input wire logic cmd_valid, // command pulse
    input wire logic [3:0] cmd_code, // command
    input wire logic cmd_auto_pre, // auto precharge
    input wire logic [2*BANKS-1:0] bank_open, // open rows
    input wire logic wr_valid, // beat ready
    input wire logic wr_ready, // beat taken
    input wire logic [2*LANES*LANE_W-1:0] wr_data, // beat data
    input wire logic wr_overflow, // lost beat
    input wire logic overflow_clr // clear
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    cmd_pulse_a: assert property (cmd_valid |=> !cmd_valid)
        else $error("command pulse longer than one cycle");
    sel_gate_a: assert property (cmd_valid |-> $past((!rank_zero_select_n &&
        rank_zero_clock_enable) || (!rank_one_select_n && rank_one_clock_enable), 3))
        else $error("command without select and enable");
    auto_pre_a: assert property (cmd_valid && cmd_code != CMD_RD &&
        cmd_code != CMD_WR |-> !cmd_auto_pre) else $error("auto precharge off access");
    strobe_pair_a: assert property (dqs_oe |-> dq_oe &&
        $past(rank_zero_clock_enable || rank_one_clock_enable, 2))
        else $error("strobe driven without data or enable");
    oe_cke_a: assert property (!(rank_zero_clock_enable || rank_one_clock_enable) [*3]
        |-> !dq_oe) else $error("drivers on with enable low");
    bank_chg_a: assert property (!$stable(bank_open) |-> cmd_valid || $past(cmd_valid))
        else $error("bank state changed without command");
    hold_beat_a: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_data))
        else $error("write beat not held");
    ovf_keep_a: assert property (wr_overflow && !overflow_clr |=> wr_overflow)
        else $error("overflow flag lost");
    cover property (cmd_valid && cmd_auto_pre);
    cover property (dq_oe);
    cover property (wr_overflow);
endmodule
bind dmc_front dmc_front_monitor #(.LANES(LANES)) u_mon (.mclk(mclk), .rst_b(rst_b),
    .rank_zero_clock_enable(rank_zero_clock_enable), .rank_one_clock_enable(rank_one_clock_enable),
    .rank_zero_select_n(rank_zero_select_n), .rank_one_select_n(rank_one_select_n),
    .dq_oe(dq_oe), .dqs_oe(dqs_oe), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_auto_pre(cmd_auto_pre), .bank_open(bank_open), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_data(wr_data), .wr_overflow(wr_overflow),
    .overflow_clr(overflow_clr));

// ===== dmc_host_model.sv
// host controller model: clock pair and write strobe bursts
`timescale 1ns/1ns
module dmc_host_model (
    input wire logic mclk, // clock
    input wire logic ck_run, // pair runs
    output logic clock_pair_zero_p, // true leg
    output logic clock_pair_zero_n, // complement leg
    output logic [7:0] dqs_in, // strobes
    output logic [63:0] dq_in // data
);
    int cnt;
    initial begin
        {clock_pair_zero_p, clock_pair_zero_n, dqs_in, dq_in} = {2'b01, 72'h0};
        cnt = 0;
    end
    // ------------------------------------------------------------
    // clock pair, six mclk a phase, parked when stopped
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        if (ck_run) begin
            cnt <= (cnt == 5) ? 0 : cnt + 1;
            if (cnt == 5) begin
                clock_pair_zero_p <= !clock_pair_zero_p;
                clock_pair_zero_n <= clock_pair_zero_p;
            end
        end
    end
    task automatic burst(input logic [63:0] d0, input logic [63:0] d1);
        @(posedge mclk) dq_in <= d0;
        repeat (3) @(posedge mclk);
        dqs_in <= 8'hff;
        repeat (3) @(posedge mclk);
        dq_in <= d1;
        repeat (3) @(posedge mclk);
        dqs_in <= 8'h00;
        repeat (3) @(posedge mclk);
        dq_in <= ~d1; // no stale beat
    endtask
endmodule

// ===== test_ddr_module_command_pins.sv
// self-checking bench for the ddr module pin front end
`timescale 1ns/1ns
module test_ddr_module_command_pins
    import dmc_pkg::*;
;
    logic mclk, rst_b, clock_pair_zero_p, clock_pair_zero_n, ck_run, ras_n, cas_n, we_n;
    logic rank_zero_clock_enable, rank_one_clock_enable, rank_zero_select_n, rank_one_select_n;
    logic dq_oe, dqs_oe, cmd_valid, cmd_rank, cmd_auto_pre, hit;
    logic wr_valid, wr_ready, wr_buf_ready, wr_overflow, overflow_clr;
    logic [1:0] bank_addr, cmd_bank;
    logic [3:0] cmd_code, rank_power;
    logic [7:0] write_mask, dqs_in, dqs_out, bank_open;
    logic [12:0] addr, cmd_addr, mode_base, mode_ext;
    logic [15:0] wr_byte_en;
    logic [63:0] dq_in, dq_out;
    logic [127:0] read_data, wr_data;
    int fail_count, comparisons, n, i;
    dmc_front u_dut (.mclk, .rst_b, .clock_pair_zero_p, .clock_pair_zero_n,
        .rank_zero_clock_enable, .rank_one_clock_enable, .rank_zero_select_n,
        .rank_one_select_n, .ras_n, .cas_n, .we_n, .bank_addr, .addr, .write_mask, .dq_in,
        .dq_out, .dq_oe, .dqs_in, .dqs_out, .dqs_oe, .cmd_valid, .cmd_code, .cmd_rank,
        .cmd_bank, .cmd_addr, .cmd_auto_pre, .mode_base, .mode_ext, .bank_open, .rank_power,
        .read_data, .wr_valid, .wr_ready, .wr_data, .wr_byte_en, .wr_buf_ready,
        .wr_overflow, .overflow_clr);
    dmc_host_model u_host (.mclk, .ck_run, .clock_pair_zero_p, .clock_pair_zero_n,
        .dqs_in, .dq_in);
    initial begin
        mclk = 0;
        forever #5 mclk = ~mclk;
    end
    task chk(input logic [127:0] g, input logic [127:0] e);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task give_verdict;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // pins set after a clock-pair fall, held across the next rise
    task cmd(input logic [1:0] s, input logic [3:0] c, input logic [1:0] b,
        input logic [12:0] a, input logic e);
        @(negedge clock_pair_zero_p);
        @(posedge mclk);
        {rank_one_select_n, rank_zero_select_n} <= s;
        {ras_n, cas_n, we_n, bank_addr, addr} <= {c[2:0], b, a};
        hit = 0;
        for (n = 0; n < 10; n++) begin
            @(negedge mclk);
            if (cmd_valid === 1'b1) hit = 1;
        end
        @(posedge mclk);
        {rank_one_select_n, rank_zero_select_n, ras_n, cas_n, we_n} <= 5'h1f;
        chk(hit, e);
        if (e) chk({cmd_code, cmd_rank, cmd_bank}, {c, s[0], b});
    endtask
    initial begin
        {rst_b, ck_run, wr_ready, overflow_clr, rank_zero_clock_enable} = 5'h09;
        {rank_one_clock_enable, rank_zero_select_n, rank_one_select_n} = 3'h7;
        {ras_n, cas_n, we_n, bank_addr, addr, write_mask, read_data} = {3'h7, 151'h0};
        {fail_count, comparisons} = 0;
        repeat (12) @(posedge mclk);
        rst_b <= 1;
        cmd(2'h2, CMD_LMR, MR_BASE, 13'h0123, 1);
        cmd(2'h2, CMD_LMR, MR_EXT, 13'h0456, 1);
        chk({mode_base, mode_ext}, {13'h0123, 13'h0456});
        cmd(2'h2, CMD_ACT, 2'h2, 13'h1abc, 1);
        chk(cmd_addr, 13'h1abc);
        cmd(2'h1, CMD_ACT, 2'h3, 13'h0001, 1);
        cmd(2'h2, CMD_ACT, 2'h1, 13'h0002, 1);
        cmd(2'h3, CMD_ACT, 2'h0, 13'h0003, 0);
        chk(bank_open, 8'h86);
        cmd(2'h2, CMD_PRE, 2'h2, 13'h0000, 1);
        chk(bank_open, 8'h82);
        cmd(2'h1, CMD_PRE, 2'h0, 13'h0400, 1);
        chk(bank_open, 8'h02);
        cmd(2'h2, CMD_REF, 2'h0, 13'h0, 1);
        cmd(2'h2, CMD_BST, 2'h0, 13'h0, 1);
        cmd(2'h2, CMD_NOP, 2'h0, 13'h0, 0);
        read_data <= {64'hfedcba9876543210, 64'h0123456789abcdef};
        write_mask <= 8'hff;
        cmd(2'h2, CMD_RD, 2'h0, 13'h0010, 1);
        for (n = 0; n < 80 && dq_oe !== 1'b1; n++) @(negedge mclk);
        chk(n > READ_LAT_DFLT * 12 - 6 && n < READ_LAT_DFLT * 12 + 2, 1);
        chk({dq_out, dqs_out, dqs_oe}, {64'h0123456789abcdef, 9'h1ff});
        for (n = 0; n < 20 && dqs_out !== 8'h00; n++) @(negedge mclk);
        chk(dq_out, 64'hfedcba9876543210);
        for (n = 0; n < 20 && dq_oe !== 1'b0; n++) @(negedge mclk);
        chk(dqs_oe, 0);
        for (i = 0; i < 5; i++) begin
            cmd(2'h2, CMD_WR, 2'h1, 13'h0400, 1);
            write_mask <= 8'h01 << i;
            u_host.burst(64'h0123456789abcdef + i, ~(64'h0123456789abcdef + i));
            if (i == 0) chk({cmd_auto_pre, bank_open}, 9'h100);
        end
        repeat (4) @(negedge mclk);
        chk({wr_buf_ready, wr_overflow}, 2'b01);
        for (i = 0; i < 4; i++) begin
            @(negedge mclk);
            chk({wr_valid, wr_byte_en}, {1'b1, ~(8'h01 << i), ~(8'h01 << i)});
            chk(wr_data, {~(64'h0123456789abcdef + i), 64'h0123456789abcdef + i});
            @(posedge mclk) wr_ready <= 1;
            @(posedge mclk) wr_ready <= 0;
        end
        @(posedge mclk) overflow_clr <= 1;
        @(posedge mclk) overflow_clr <= 0;
        @(negedge mclk) chk({wr_valid, wr_overflow}, 0);
        cmd(2'h1, CMD_ACT, 2'h0, 13'h0005, 1);
        {rank_zero_clock_enable, rank_one_clock_enable} <= 2'h0;
        cmd(2'h3, CMD_NOP, 2'h0, 13'h0, 0);
        chk(rank_power, {DMC_PWR_ACT_PD, DMC_PWR_PRE_PD});
        {rank_zero_clock_enable, rank_one_clock_enable} <= 2'h3;
        cmd(2'h3, CMD_NOP, 2'h0, 13'h0, 0);
        chk(rank_power, 4'h0);
        rank_zero_clock_enable <= 0;
        cmd(2'h2, CMD_REF, 2'h0, 13'h0, 0);
        chk(rank_power[1:0], DMC_PWR_SELF);
        {ck_run, rank_zero_clock_enable} <= 2'h1;
        repeat (5) @(negedge mclk);
        chk(rank_power[1:0], DMC_PWR_ON);
        give_verdict;
    end
    initial begin
        #300000;
        fail_count++;
        give_verdict;
    end
endmodule
